// file: design/lsr_pkg.sv
// constants and types for the light sensor serial register port
package lsr_pkg;
    // slave addresses selected by the strap
    localparam logic [6:0] ADDR_STRAP_LO = 7'h10;
    localparam logic [6:0] ADDR_STRAP_HI = 7'h11;
    // register offsets
    localparam logic [7:0] OFF_PROD_LO   = 8'h00;
    localparam logic [7:0] OFF_PROD_HI   = 8'h01;
    localparam logic [7:0] OFF_OP_SETUP  = 8'h03;
    localparam logic [7:0] OFF_INT_PER   = 8'h04;
    localparam logic [7:0] OFF_GAIN_SEL  = 8'h05;
    // reset values
    localparam logic [3:0] OP_SETUP_RST  = 4'h4;
    localparam logic [7:0] INT_PER_RST   = 8'h94;
    localparam logic [7:0] GAIN_SEL_RST  = 8'hff;
    localparam logic [3:0] GAIN_MUL_RST  = 4'hf;
    // field positions
    localparam int         PD_BIT        = 1;
    // bit counts
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // integration unit: 2.7 ms at 20 MHz
    localparam int         UNIT_NS       = 2700000;
    localparam int         CLK_PERIOD_NS = 50;
    localparam int         UNIT_CYC      = UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_MACK, ST_SKIP
    } lsr_state_t;
endpackage

// file: design/lsr_i2c_port.sv
// two-wire slave port, register map and integration timer of the light sensor
`timescale 1ns/1ps
module lsr_i2c_port #(
    parameter int         UNIT_CYC = lsr_pkg::UNIT_CYC,
    parameter logic [7:0] PROD_LO  = 8'h5a,  // arbitrary value
    parameter logic [7:0] PROD_HI  = 8'ha5   // arbitrary value
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // bus pins
    input  wire logic        scl_pin,
    input  wire logic        sda_pin_in,
    output logic             sda_pin_out,
    output logic             sda_pin_oe,
    input  wire logic        addr_strap,
    // converter side
    input  wire logic [15:0] bb_adc,
    input  wire logic [15:0] ir_adc,
    output logic             conv_done,
    output logic [15:0]      broadband_channel_result,
    output logic [15:0]      infrared_channel_result,
    // control out
    output logic             power_down_ctl,
    output logic [7:0]       integration_time_field,
    output logic [3:0]       gain_multiplier
);
    localparam int UW = $clog2(UNIT_CYC + 1);

    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, strap_m, strap_s;
    logic rise, fall, start, stop;
    lsr_pkg::lsr_state_t st_q;
    logic [3:0] cnt_q, op_q;
    logic [7:0] sh_q, tx_q, ptr_q;
    logic       rw_q, first_q, mack_q;
    logic [6:0] my_addr;
    logic [7:0] tig_q, cg_q;
    logic [7:0] rd_byte;
    logic       rd_load;
    // two-entry write buffer
    logic [15:0] buf_mem [2];
    logic        buf_wp, buf_rp;
    logic [1:0]  buf_cnt;
    logic        fill_valid, fill_ready, drain_valid, drain_ready;
    logic [15:0] drain_data;
    // timer
    logic [UW-1:0] unit_q;
    logic [7:0]    per_q;
    logic          end_conv;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [3:0] op,
                                            input logic [7:0] integration_time, input logic [7:0] cg);
        if (a == lsr_pkg::OFF_PROD_LO) begin
            reg_read = PROD_LO;
        end else if (a == lsr_pkg::OFF_PROD_HI) begin
            reg_read = PROD_HI;
        end else if (a == lsr_pkg::OFF_OP_SETUP) begin
            reg_read = {4'h0, op};
        end else if (a == lsr_pkg::OFF_INT_PER) begin
            reg_read = integration_time;
        end else if (a == lsr_pkg::OFF_GAIN_SEL) begin
            reg_read = cg;
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_m   <= 1'b1;
            scl_s   <= 1'b1;
            scl_d   <= 1'b1;
            sda_m   <= 1'b1;
            sda_s   <= 1'b1;
            sda_d   <= 1'b1;
            strap_m <= 1'b0;
            strap_s <= 1'b0;
        end else begin
            scl_m   <= scl_pin;
            scl_s   <= scl_m;
            scl_d   <= scl_s;
            sda_m   <= sda_pin_in;
            sda_s   <= sda_m;
            sda_d   <= sda_s;
            strap_m <= addr_strap;
            strap_s <= strap_m;
        end
    end

    assign rise    = scl_s & ~scl_d;
    assign fall    = ~scl_s & scl_d;
    assign start   = scl_s & scl_d & sda_d & ~sda_s;
    assign stop    = scl_s & scl_d & ~sda_d & sda_s;
    assign my_addr = strap_s ? lsr_pkg::ADDR_STRAP_HI : lsr_pkg::ADDR_STRAP_LO;
    assign rd_byte = reg_read(ptr_q, op_q, tig_q, cg_q);
    assign rd_load = fall & ((st_q == lsr_pkg::ST_ACK & rw_q) |
                             (st_q == lsr_pkg::ST_MACK & ~mack_q));
    assign fill_valid = fall & st_q == lsr_pkg::ST_WR & cnt_q == lsr_pkg::BITS_PER_BYTE
                        & ~first_q;
    assign fill_ready = buf_cnt != 2'd2;

    // bus state machine, oversampled by clk for both bus speeds
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q    <= lsr_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            tx_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
            mack_q  <= 1'b1;
            sda_pin_oe <= 1'b0;
            sda_pin_out <= 1'b0; // open drain, only ever pulls low
        end else if (stop) begin
            st_q       <= lsr_pkg::ST_IDLE;
            sda_pin_oe <= 1'b0;
        end else if (start) begin
            st_q       <= lsr_pkg::ST_ADDR;
            cnt_q      <= 4'h0;
            sda_pin_oe <= 1'b0;
        end else begin
            case (st_q)
                lsr_pkg::ST_ADDR: begin
                    if (rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (fall && cnt_q == lsr_pkg::BITS_PER_BYTE) begin
                        if (sh_q[7:1] == my_addr) begin
                            sda_pin_oe <= 1'b1;
                            rw_q       <= sh_q[0];
                            first_q    <= ~sh_q[0];
                            st_q       <= lsr_pkg::ST_ACK;
                        end else begin
                            st_q <= lsr_pkg::ST_SKIP;
                        end
                    end
                end
                lsr_pkg::ST_ACK: begin
                    if (fall) begin
                        if (rw_q) begin
                            tx_q       <= rd_byte;
                            ptr_q      <= ptr_q + 8'h01;
                            sda_pin_oe <= ~rd_byte[7];
                            cnt_q      <= 4'h1;
                            st_q       <= lsr_pkg::ST_RD;
                        end else begin
                            sda_pin_oe <= 1'b0;
                            cnt_q      <= 4'h0;
                            st_q       <= lsr_pkg::ST_WR;
                        end
                    end
                end
                lsr_pkg::ST_WR: begin
                    if (rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (fall && cnt_q == lsr_pkg::BITS_PER_BYTE) begin
                        st_q    <= lsr_pkg::ST_ACK;
                        first_q <= 1'b0;
                        if (first_q) begin
                            ptr_q      <= sh_q;
                            sda_pin_oe <= 1'b1;
                        end else if (fill_ready) begin
                            ptr_q      <= ptr_q + 8'h01;
                            sda_pin_oe <= 1'b1;
                        end else begin
                            sda_pin_oe <= 1'b0;
                        end
                    end
                end
                lsr_pkg::ST_RD: begin
                    if (fall) begin
                        if (cnt_q == lsr_pkg::BITS_PER_BYTE) begin
                            sda_pin_oe <= 1'b0;
                            st_q       <= lsr_pkg::ST_MACK;
                        end else begin
                            tx_q       <= {tx_q[6:0], 1'b0};
                            sda_pin_oe <= ~tx_q[6];
                            cnt_q      <= cnt_q + 4'h1;
                        end
                    end
                end
                lsr_pkg::ST_MACK: begin
                    if (rise) begin
                        mack_q <= sda_s;
                    end else if (fall) begin
                        if (!mack_q) begin
                            tx_q       <= rd_byte;
                            ptr_q      <= ptr_q + 8'h01;
                            sda_pin_oe <= ~rd_byte[7];
                            cnt_q      <= 4'h1;
                            st_q       <= lsr_pkg::ST_RD;
                        end else begin
                            st_q <= lsr_pkg::ST_SKIP;
                        end
                    end
                end
                default: begin
                    sda_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // write buffer; register port busy with a read load stalls the drain
    assign drain_valid = buf_cnt != 2'd0;
    assign drain_ready = ~rd_load;
    assign drain_data  = buf_mem[buf_rp];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            buf_wp  <= 1'b0;
            buf_rp  <= 1'b0;
            buf_cnt <= 2'd0;
            buf_mem[0] <= 16'h0000;
            buf_mem[1] <= 16'h0000;
        end else begin
            if (fill_valid && fill_ready) begin
                buf_mem[buf_wp] <= {ptr_q, sh_q};
                buf_wp          <= ~buf_wp;
            end
            if (drain_valid && drain_ready) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + 2'(fill_valid && fill_ready) - 2'(drain_valid && drain_ready);
        end
    end

    // register file
    always_ff @(posedge clk) begin
        if (!nrst) begin
            op_q  <= lsr_pkg::OP_SETUP_RST;
            tig_q <= lsr_pkg::INT_PER_RST;
            cg_q  <= lsr_pkg::GAIN_SEL_RST;
        end else if (drain_valid && drain_ready) begin
            if (drain_data[15:8] == lsr_pkg::OFF_OP_SETUP) begin
                op_q <= drain_data[3:0];
            end else if (drain_data[15:8] == lsr_pkg::OFF_INT_PER) begin
                tig_q <= drain_data[7:0];
            end else if (drain_data[15:8] == lsr_pkg::OFF_GAIN_SEL) begin
                cg_q <= drain_data[7:0];
            end
        end
    end

    // control outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            power_down_ctl         <= 1'b0;
            integration_time_field <= lsr_pkg::INT_PER_RST;
            gain_multiplier        <= lsr_pkg::GAIN_MUL_RST;
        end else begin
            power_down_ctl         <= op_q[lsr_pkg::PD_BIT];
            integration_time_field <= tig_q;
            if (cg_q[7:4] == cg_q[3:0]) begin
                gain_multiplier <= cg_q[3:0];
            end
        end
    end

    // integration timer in 2.7 ms units
    assign end_conv = unit_q == UW'(UNIT_CYC - 1) && ({1'b0, per_q} + 9'h001 >= {1'b0, tig_q});
    always_ff @(posedge clk) begin
        if (!nrst || power_down_ctl) begin
            unit_q <= '0;
            per_q  <= 8'h00;
        end else if (unit_q == UW'(UNIT_CYC - 1)) begin
            unit_q <= '0;
            per_q  <= end_conv ? 8'h00 : per_q + 8'h01;
        end else begin
            unit_q <= unit_q + UW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            conv_done                <= 1'b0;
            broadband_channel_result <= 16'h0000;
            infrared_channel_result  <= 16'h0000;
        end else begin
            conv_done <= end_conv;
            if (end_conv) begin
                broadband_channel_result <= bb_adc;
                infrared_channel_result  <= ir_adc;
            end
        end
    end

    a_stop_to_idle: assert property (@(posedge clk) disable iff (!nrst)
        stop |=> st_q == lsr_pkg::ST_IDLE && !sda_pin_oe) else $error("stop not honoured");
    a_start_to_addr: assert property (@(posedge clk) disable iff (!nrst)
        start && !stop |=> st_q == lsr_pkg::ST_ADDR && cnt_q == 4'h0) else $error("start missed");
    a_addr_ack_drive: assert property (@(posedge clk) disable iff (!nrst)
        st_q == lsr_pkg::ST_ADDR && fall && cnt_q == 4'h8 && sh_q[7:1] == my_addr && !start && !stop
        |=> sda_pin_oe) else $error("no address acknowledge");
    a_mismatch_silent: assert property (@(posedge clk) disable iff (!nrst)
        st_q == lsr_pkg::ST_SKIP |-> !sda_pin_oe) else $error("drive while ignored");
    a_sda_change_low: assert property (@(posedge clk) disable iff (!nrst)
        $changed(sda_pin_oe) && !$past(start) && !$past(stop) |-> !$past(scl_s))
        else $error("sda changed with scl high");
    a_pd_halts_conv: assert property (@(posedge clk) disable iff (!nrst)
        power_down_ctl [*3] |-> !conv_done) else $error("conversion in power-down");
    a_conv_latch: assert property (@(posedge clk) disable iff (!nrst)
        end_conv |=> conv_done && broadband_channel_result == $past(bb_adc)
        && infrared_channel_result == $past(ir_adc) && per_q == 8'h00) else $error("result not latched");
    a_ro_no_write: assert property (@(posedge clk) disable iff (!nrst)
        drain_valid && drain_ready && (drain_data[15:8] < lsr_pkg::OFF_OP_SETUP
        || drain_data[15:8] > lsr_pkg::OFF_GAIN_SEL)
        |=> $stable(op_q) && $stable(tig_q) && $stable(cg_q)) else $error("read-only altered");
    a_sample_rise: assert property (@(posedge clk) disable iff (!nrst)
        st_q == lsr_pkg::ST_WR && rise && !start && !stop |=> sh_q[0] == $past(sda_s))
        else $error("bit not sampled");
endmodule

// file: test/lsr_master_model.sv
// two-wire bus master model facing the sensor port
`timescale 1ns/1ps
module lsr_master_model (
    // clock
    input  wire logic clk,
    // bus
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_wire
);
    int         half = 4;
    logic [7:0] wbuf [8];
    logic [7:0] rbuf [8];
    logic       acks [10];
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves with scl low, read at end of high
    task automatic bit_xfer(input logic b, output logic s);
        cyc(1);
        sda_low <= !b;
        cyc(half - 1);
        scl <= 1'b1;
        cyc(half);
        s = sda_wire;
        scl <= 1'b0;
    endtask
    task automatic bus_start();
        cyc(1);
        sda_low <= 1'b0;
        cyc(half - 1);
        scl <= 1'b1;
        cyc(half);
        sda_low <= 1'b1;
        cyc(half);
        scl <= 1'b0;
    endtask
    task automatic bus_stop();
        cyc(1);
        sda_low <= 1'b1;
        cyc(half - 1);
        scl <= 1'b1;
        cyc(half);
        sda_low <= 1'b0;
        cyc(half);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'b1, ack_n);
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(last, s);
    endtask
    task automatic write_tx(input logic [6:0] a, input logic [7:0] ptr, input int n);
        bus_start();
        put_byte({a, 1'b0}, acks[0]);
        if (acks[0]) begin
            bus_stop();
            return;
        end
        put_byte(ptr, acks[1]);
        for (int i = 0; i < n; i++) put_byte(wbuf[i], acks[i + 2]);
        bus_stop();
    endtask
    task automatic read_tx(input logic [6:0] a, input logic [7:0] ptr, input int n);
        bus_start();
        put_byte({a, 1'b0}, acks[0]);
        if (!acks[0]) begin
            put_byte(ptr, acks[1]);
            bus_start();
            put_byte({a, 1'b1}, acks[2]);
            for (int i = 0; i < n; i++) get_byte(i == n - 1, rbuf[i]);
        end
        bus_stop();
    endtask
endmodule

// file: test/lsr_i2c_port_tb.sv
// self-checking bench for the light sensor serial register port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module lsr_i2c_port_tb;
    localparam int         UNIT = 4;
    localparam logic [7:0] PLO  = 8'h3c;  // arbitrary value
    localparam logic [7:0] PHI  = 8'hc3;  // arbitrary value
    logic        clk, nrst, strap, sda_out, sda_oe, done, pd_o, m_low, scl;
    logic [15:0] bb_adc, ir_adc, bb_res, ir_res, bbv, irv;
    logic [7:0]  tif_o, tig_e, cg_e;
    logic [3:0]  gm_o, op_e, gm_e;
    logic [6:0]  dev_a;
    int          bad_count, check_count, c;
    wire         sda_wire = !(sda_oe && !sda_out) && !m_low;
    lsr_master_model m (.clk(clk), .scl(scl), .sda_low(m_low), .sda_wire(sda_wire));
    lsr_i2c_port #(.UNIT_CYC(UNIT), .PROD_LO(PLO), .PROD_HI(PHI)) DUT (
        .clk(clk), .nrst(nrst), .scl_pin(scl), .sda_pin_in(sda_wire),
        .sda_pin_out(sda_out), .sda_pin_oe(sda_oe), .addr_strap(strap),
        .bb_adc(bb_adc), .ir_adc(ir_adc), .conv_done(done),
        .broadband_channel_result(bb_res), .infrared_channel_result(ir_res),
        .power_down_ctl(pd_o), .integration_time_field(tif_o), .gain_multiplier(gm_o));
    always #25 clk = ~clk;
    function automatic logic [7:0] exp_rd(input logic [7:0] off);
        case (off)
            lsr_pkg::OFF_PROD_LO:  return PLO;
            lsr_pkg::OFF_PROD_HI:  return PHI;
            lsr_pkg::OFF_OP_SETUP: return {4'h0, op_e};
            lsr_pkg::OFF_INT_PER:  return tig_e;
            lsr_pkg::OFF_GAIN_SEL: return cg_e;
            default:               return 8'h00;
        endcase
    endfunction
    function automatic void apply(input logic [7:0] off, input logic [7:0] d);
        if (off == lsr_pkg::OFF_OP_SETUP) op_e = d[3:0];
        if (off == lsr_pkg::OFF_INT_PER) tig_e = d;
        if (off == lsr_pkg::OFF_GAIN_SEL) begin
            cg_e = d;
            if (d[7:4] == d[3:0]) gm_e = d[3:0];
        end
    endfunction
    task automatic wr(input logic [7:0] ptr, input int n);
        m.write_tx(dev_a, ptr, n);
        `CHK("addr ack", 1'b0, m.acks[0])
        `CHK("ptr ack", 1'b0, m.acks[1])
        for (int i = 0; i < n; i++) begin
            `CHK("data ack", 1'b0, m.acks[i + 2])
            apply(ptr + 8'(i), m.wbuf[i]);
        end
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        m.read_tx(dev_a, ptr, n);
        `CHK("read ack", 1'b0, m.acks[2])
        `CHK("read ptr ack", 1'b0, m.acks[1])
        for (int i = 0; i < n; i++) `CHK("reg", exp_rd(ptr + 8'(i)), m.rbuf[i])
    endtask
    task automatic ports();
        `CHK("power down", op_e[lsr_pkg::PD_BIT], pd_o)
        `CHK("int time", tig_e, tif_o)
        `CHK("gain mul", gm_e, gm_o)
    endtask
    task automatic wait_done();
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (done !== 1'b1 && c < 2000);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #4_000_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        strap = 1'b0;
        bb_adc = 16'h0000;
        ir_adc = 16'h0000;
        dev_a = lsr_pkg::ADDR_STRAP_LO;
        op_e = lsr_pkg::OP_SETUP_RST;
        tig_e = lsr_pkg::INT_PER_RST;
        cg_e = lsr_pkg::GAIN_SEL_RST;
        gm_e = lsr_pkg::GAIN_MUL_RST;
        void'($urandom(69));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("oe idle", 1'b0, sda_oe)
        ports();
        rd(8'h00, 8);
        // foreign addresses get no answer and change nothing
        for (int j = 0; j < 2; j++) begin
            m.wbuf[0] = 8'h33;
            m.write_tx(j ? 7'h11 : {3'b100, 4'($urandom)}, lsr_pkg::OFF_GAIN_SEL, 1);
            `CHK("foreign ack", 1'b1, m.acks[0])
            ports();
        end
        // random bursts over the whole map
        repeat (4) begin
            for (int i = 0; i < 8; i++) m.wbuf[i] = 8'($urandom);
            m.wbuf[3] = {4'($urandom), 2'b01, 1'($urandom), 1'b0};
            wr(8'h00, 8);
            rd(8'h00, 8);
            ports();
            wr(8'h06, 4);
            rd(8'hfe, 8);
        end
        // gain codes, unequal nibbles first
        for (int k = 0; k < 16; k++) begin
            m.wbuf[0] = (k == 0) ? 8'h12 : {2{4'(k)}};
            wr(lsr_pkg::OFF_GAIN_SEL, 1);
            ports();
        end
        strap <= 1'b1;
        dev_a = lsr_pkg::ADDR_STRAP_HI;
        repeat (6) @(posedge clk);
        rd(8'h00, 2);
        m.read_tx(lsr_pkg::ADDR_STRAP_LO, 8'h00, 1);
        `CHK("low addr ack", 1'b1, m.acks[0])
        m.half = 100;
        rd(8'h03, 3);
        m.half = 4;
        // conversion timing and result capture
        m.wbuf[0] = 8'h04;
        m.wbuf[1] = 8'h02;
        wr(lsr_pkg::OFF_OP_SETUP, 2);
        wait_done();
        repeat (4) begin
            bbv = 16'($urandom);
            irv = 16'($urandom);
            bb_adc <= bbv;
            ir_adc <= irv;
            wait_done();
            `CHK("period", 2 * UNIT, c)
            `CHK("bb result", bbv, bb_res)
            `CHK("ir result", irv, ir_res)
        end
        // offsets 0x20 to 0x24 lie outside the map and read as zero
        rd(8'h20, 5);
        m.wbuf[0] = 8'h06;
        wr(lsr_pkg::OFF_OP_SETUP, 1);
        ports();
        c = 0;
        repeat (40) begin
            @(posedge clk);
            if (done !== 1'b0) c++;
        end
        `CHK("pulses in power down", 0, c)
        m.wbuf[0] = 8'h04;
        wr(lsr_pkg::OFF_OP_SETUP, 1);
        wait_done();
        `CHK("resume", 1'b1, done)
        report_and_stop();
    end
endmodule
